// file: design/csw_pkg.sv
// Constants for the socket window and card detect register bank
package csw_pkg;

    // ==========================================================
    // Register offsets (first socket; second socket adds stride)
    localparam logic [11:0] WIN0_OFFSET = 12'h815;
    localparam logic [11:0] WIN1_OFFSET = 12'h81D;
    localparam logic [11:0] WIN2_OFFSET = 12'h825;
    localparam logic [11:0] WIN3_OFFSET = 12'h82D;
    localparam logic [11:0] WIN4_OFFSET = 12'h835;
    localparam logic [11:0] DETECT_OFFSET = 12'h816;
    localparam logic [11:0] GLOBAL_OFFSET = 12'h81E;
    localparam int SOCKET_SEL_BIT = 6;

    // ==========================================================
    // Sizes
    localparam int NUM_SOCKETS = 2;
    localparam int NUM_WINDOWS = 5;
    localparam int OFFSET_BITS = 6;

    // ==========================================================
    // Window upper offset fields
    localparam int WIN_WP_BIT = 7;
    localparam int WIN_ATTR_BIT = 6;
    localparam int WIN_OFFS_LSB = 0;

    // ==========================================================
    // Card detect and general control fields
    localparam int DET_SENSE2_BIT = 7;
    localparam int DET_SENSE1_BIT = 6;
    localparam int DET_TRIGGER_BIT = 5;
    localparam int DET_WAKE_BIT = 4;
    localparam int DET_CLR_REMOVAL_BIT = 1;

    // ==========================================================
    // Global control fields
    localparam int GLB_FLAG_CLEAR_BIT = 2;

    // ==========================================================
    // Values after reset and idle values
    localparam logic [7:0] WIN_RESET = 8'h00;
    localparam logic [7:0] READ_IDLE = 8'h00;
    localparam logic [1:0] PRIME_RESET = 2'h0;

endpackage : csw_pkg

// file: design/csw_socket_regs.sv
// Per-socket window upper offset and card detect register bank
`timescale 1ns/1ps
`default_nettype none

module csw_socket_regs (
    // Clock and resets
    input wire logic mclk,
    input wire logic srst,
    input wire logic platform_reset,
    input wire logic pme_enable,
    // Register port, one byte per access
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [11:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // Card pins, index is socket; card_detect_n holds two bits per socket
    input wire logic [1:0] first_sense_level,
    input wire logic [1:0] second_sense_level,
    input wire logic [3:0] card_detect_n,
    // Status-change block of each socket
    input wire logic [1:0] detect_enable,
    input wire logic [1:0] status_change_clear,
    input wire logic [1:0] detect_flag_write1,
    output logic [1:0] soft_detect_trigger,
    output logic [1:0] ring_indicate_output_n,
    // Window controls toward the memory mapper; flag clear mode toward the status block
    output logic [59:0] offset_upper_bits,
    output logic [9:0] window_write_protect,
    output logic [9:0] window_attribute_select,
    output logic flag_clear_select
);

    // ==========================================================
    // Address decode
    localparam int NS = csw_pkg::NUM_SOCKETS;
    localparam int NW = csw_pkg::NUM_WINDOWS;

    logic [11:0] local_addr;
    logic sock_sel;
    logic [NW-1:0] hit_win;
    logic hit_detect;
    logic hit_global;

    // Fold the second socket onto the first socket's map
    assign sock_sel = reg_addr[csw_pkg::SOCKET_SEL_BIT];
    assign local_addr = reg_addr &
        ~(12'h001 << csw_pkg::SOCKET_SEL_BIT);
    assign hit_win[0] = (local_addr == csw_pkg::WIN0_OFFSET);
    assign hit_win[1] = (local_addr == csw_pkg::WIN1_OFFSET);
    assign hit_win[2] = (local_addr == csw_pkg::WIN2_OFFSET);
    assign hit_win[3] = (local_addr == csw_pkg::WIN3_OFFSET);
    assign hit_win[4] = (local_addr == csw_pkg::WIN4_OFFSET);
    assign hit_detect = (local_addr == csw_pkg::DETECT_OFFSET);
    // Global control is shared: both socket aliases reach it
    assign hit_global = (local_addr == csw_pkg::GLOBAL_OFFSET);

    // ==========================================================
    // Global flag clear mode
    logic flag_clear_reg;

    always_ff @(posedge mclk) begin
        if (srst) begin
            flag_clear_reg <= 1'b0;
        end else if (reg_wr && hit_global) begin
            flag_clear_reg <= reg_wdata[csw_pkg::GLB_FLAG_CLEAR_BIT];
        end
    end

    // Status block clears on read when low, on writeback when high
    assign flag_clear_select = flag_clear_reg;

    // ==========================================================
    // Per-socket state
    logic [7:0] win_reg [NS][NW];
    logic [NS-1:0] wake_reg;
    logic [NS-1:0] clr_removal_reg;
    logic [NS-1:0] trig_reg;
    logic [NS-1:0] ring_n_reg;
    logic [NS-1:0] sense1_reg;
    logic [NS-1:0] sense2_reg;
    logic [7:0] detect_view [NS];

    genvar gs;
    genvar gw;
    generate
        for (gs = 0; gs < NS; gs++) begin : g_sock
            logic [1:0] cd_reg;
            logic [1:0] cd_prev_reg;
            logic [1:0] prime_reg;
            logic cd_change;
            logic removal;
            logic sock_hit;
            logic wr_detect;
            logic trig_set;
            logic wipe_all;
            logic wipe_marked;
            logic [NW-1:0] wr_win;

            assign sock_hit = (sock_sel == 1'(gs));
            assign wr_detect = reg_wr && sock_hit && hit_detect;
            assign wr_win = {NW{reg_wr && sock_hit}} & hit_win;

            // Edge history is only trusted once two samples exist
            assign cd_change = prime_reg[1] && (cd_reg != cd_prev_reg);
            assign removal = prime_reg[1] && (cd_prev_reg == 2'h0) &&
                (cd_reg != 2'h0);

            // Removal wipe honours the option bit
            assign wipe_all = platform_reset ||
                (removal && clr_removal_reg[gs]);
            // Wake bits ride through platform reset while PME is on
            assign wipe_marked = (platform_reset && !pme_enable) ||
                (removal && clr_removal_reg[gs]);

            assign trig_set = wr_detect &&
                reg_wdata[csw_pkg::DET_TRIGGER_BIT] &&
                detect_enable[gs];

            // Pin sampling; no reset, values are live levels
            always_ff @(posedge mclk) begin
                cd_reg <= card_detect_n[2*gs +: 2];
                cd_prev_reg <= cd_reg;
                sense1_reg[gs] <= first_sense_level[gs];
                sense2_reg[gs] <= second_sense_level[gs];
            end

            always_ff @(posedge mclk) begin
                if (srst || platform_reset) begin
                    prime_reg <= csw_pkg::PRIME_RESET;
                end else begin
                    prime_reg <= {prime_reg[0], 1'b1};
                end
            end

            for (gw = 0; gw < NW; gw++) begin : g_win
                always_ff @(posedge mclk) begin
                    if (srst || wipe_all) begin
                        win_reg[gs][gw] <= csw_pkg::WIN_RESET;
                    end else if (wr_win[gw]) begin
                        win_reg[gs][gw] <= reg_wdata;
                    end
                end
                assign offset_upper_bits[(gs*NW+gw)*6 +: 6] =
                    win_reg[gs][gw][csw_pkg::WIN_OFFS_LSB +:
                    csw_pkg::OFFSET_BITS];
                assign window_write_protect[gs*NW+gw] =
                    win_reg[gs][gw][csw_pkg::WIN_WP_BIT];
                assign window_attribute_select[gs*NW+gw] =
                    win_reg[gs][gw][csw_pkg::WIN_ATTR_BIT];
            end

            always_ff @(posedge mclk) begin
                if (srst || wipe_marked) begin
                    wake_reg[gs] <= 1'b0;
                    clr_removal_reg[gs] <= 1'b0;
                end else if (wr_detect) begin
                    wake_reg[gs] <= reg_wdata[csw_pkg::DET_WAKE_BIT];
                    clr_removal_reg[gs] <=
                        reg_wdata[csw_pkg::DET_CLR_REMOVAL_BIT];
                end
            end

            // One-cycle event; the self-clear also covers the
            // writeback clear, and a new write wins over both
            always_ff @(posedge mclk) begin
                if (srst) begin
                    trig_reg[gs] <= 1'b0;
                end else if (trig_set) begin
                    trig_reg[gs] <= 1'b1;
                end else if (flag_clear_reg && detect_flag_write1[gs]) begin
                    trig_reg[gs] <= 1'b0;
                end else begin
                    trig_reg[gs] <= 1'b0;
                end
            end

            // A change in the clearing cycle keeps the line low
            always_ff @(posedge mclk) begin
                if (srst || wipe_marked) begin
                    ring_n_reg[gs] <= 1'b1;
                end else if (wake_reg[gs] && cd_change) begin
                    ring_n_reg[gs] <= 1'b0;
                end else if (status_change_clear[gs]) begin
                    ring_n_reg[gs] <= 1'b1;
                end
            end

            // Trigger reads as zero; reserved bits read as zero
            assign detect_view[gs] = {sense2_reg[gs], sense1_reg[gs],
                1'b0, wake_reg[gs], 2'h0, clr_removal_reg[gs],
                1'b0};
        end
    endgenerate

    assign soft_detect_trigger = trig_reg;
    assign ring_indicate_output_n = ring_n_reg;

    // ==========================================================
    // Read path, one cycle after the strobe
    logic [7:0] rd_sel;
    logic [7:0] win_rd;
    logic [7:0] rdata_reg;

    always_comb begin
        win_rd = csw_pkg::READ_IDLE;
        for (int w = 0; w < NW; w++) begin
            if (hit_win[w]) begin
                win_rd = win_reg[sock_sel][w];
            end
        end
    end

    assign rd_sel = hit_detect ? detect_view[sock_sel] :
        hit_global ? {5'h00, flag_clear_reg, 2'h0} :
        win_rd;

    always_ff @(posedge mclk) begin
        if (srst) begin
            rdata_reg <= csw_pkg::READ_IDLE;
        end else if (reg_rd) begin
            rdata_reg <= rd_sel;
        end
    end

    assign reg_rdata = rdata_reg;

endmodule : csw_socket_regs

`default_nettype wire

// file: testbench/csw_regs_asserts.sv
// Checker for the socket window and card detect register bank
`timescale 1ns/1ps
`default_nettype none
module csw_regs_chk (
    // Clock and resets
    input wire logic mclk,
    input wire logic srst,
    input wire logic platform_reset,
    input wire logic pme_enable,
    // Register port
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [11:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    // Socket side
    input wire logic [1:0] first_sense_level,
    input wire logic [1:0] second_sense_level,
    input wire logic [1:0] detect_enable,
    input wire logic [1:0] status_change_clear,
    input wire logic [1:0] soft_detect_trigger,
    input wire logic [1:0] ring_indicate_output_n,
    input wire logic [59:0] offset_upper_bits,
    input wire logic [9:0] window_write_protect,
    input wire logic [9:0] window_attribute_select,
    input wire logic flag_clear_select
);
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    wire fire0 = reg_wr && reg_addr == 12'h816 && reg_wdata[5] && detect_enable[0];

    a_win_write: assert property (reg_wr && reg_addr == 12'h815 && !platform_reset
        |=> {window_write_protect[0], window_attribute_select[0],
        offset_upper_bits[5:0]} == $past(reg_wdata)) else $error("window 0 bad");
    a_trig_fire: assert property (fire0 |=> soft_detect_trigger[0])
        else $error("trigger missing");
    a_trig_block: assert property (!fire0 |=> !soft_detect_trigger[0])
        else $error("trigger without enabled write");
    a_detect_read: assert property (reg_rd && reg_addr == 12'h816 |=>
        reg_rdata[7:5] == {$past(second_sense_level[0], 2),
        $past(first_sense_level[0], 2), 1'b0} && reg_rdata[3:2] == 2'h0
        && !reg_rdata[0]) else $error("detect readback bad");
    a_rdata_hold: assert property (!reg_rd && !platform_reset |=>
        $stable(reg_rdata)) else $error("read data moved");
    a_ring_hold: assert property (!ring_indicate_output_n[0] &&
        !status_change_clear[0] && !(platform_reset && !pme_enable)
        |=> !ring_indicate_output_n[0]) else $error("ring released early");
    a_reset_vals: assert property ($fell(srst) |-> offset_upper_bits == 60'h0
        && window_write_protect == 10'h0 && ring_indicate_output_n == 2'h3)
        else $error("reset values bad");
    a_flag_mode: assert property (reg_wr && reg_addr == 12'h81E |=>
        flag_clear_select == $past(reg_wdata[2])) else $error("flag mode bad");
endmodule : csw_regs_chk
bind csw_socket_regs csw_regs_chk u_chk (.*);
`default_nettype wire

// file: testbench/csw_card_model.sv
// Behavioural PC Card model for both sockets
`timescale 1ns/1ps
`default_nettype none
module csw_card_model (
    // Card state per socket
    input wire logic [1:0] present,
    input wire logic [1:0] vs1,
    input wire logic [1:0] vs2,
    // Socket pins
    output logic [1:0] first_sense_level,
    output logic [1:0] second_sense_level,
    output logic [3:0] card_detect_n
);
    // Empty socket: every pin floats to its pull-up
    assign first_sense_level = vs1 | ~present;
    assign second_sense_level = vs2 | ~present;
    assign card_detect_n = {{2{~present[1]}}, {2{~present[0]}}};
endmodule : csw_card_model
`default_nettype wire

// file: testbench/csw_socket_regs_tb.sv
// Self-checking bench for the socket register bank
`timescale 1ns/1ps
`default_nettype none
module csw_socket_regs_tb;
    logic mclk = 0, srst = 1, platform_reset = 0, pme_enable = 0;
    logic reg_wr = 0, reg_rd = 0, flag_clear_select;
    logic [11:0] reg_addr = 12'h000;
    logic [7:0] reg_wdata = 8'h00, reg_rdata;
    logic [1:0] present = 2'h3, vs1 = 2'h0, vs2 = 2'h0, detect_enable = 2'h0;
    logic [1:0] status_change_clear = 2'h0, soft_detect_trigger;
    logic [1:0] detect_flag_write1 = 2'h0;
    logic [1:0] first_sense_level, second_sense_level, ring_indicate_output_n;
    logic [3:0] card_detect_n;
    logic [59:0] offset_upper_bits;
    logic [9:0] window_write_protect, window_attribute_select;
    int errors = 0, cmp_count = 0, cycles = 0;
    always #2.5 mclk = ~mclk;
    csw_card_model u_card (.present, .vs1, .vs2, .first_sense_level,
        .second_sense_level, .card_detect_n);
    csw_socket_regs u_dut (.mclk, .srst, .platform_reset, .pme_enable,
        .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
        .first_sense_level, .second_sense_level, .card_detect_n,
        .detect_enable, .status_change_clear, .detect_flag_write1,
        .soft_detect_trigger, .ring_indicate_output_n, .offset_upper_bits,
        .window_write_protect, .window_attribute_select, .flag_clear_select);
    task automatic chk(input logic [59:0] seen, exp, input string msg);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %0t %s", $time, msg);
        end
    endtask : chk
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(negedge mclk);
        reg_wr = 1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge mclk);
        reg_wr = 0;
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [7:0] e, string m);
        @(negedge mclk);
        reg_rd = 1;
        reg_addr = a;
        @(negedge mclk);
        reg_rd = 0;
        chk(reg_rdata, e, m);
    endtask : rd
    task automatic t_windows;
        logic [11:0] a;
        logic [7:0] v;
        for (int i = 0; i < 10; i++) begin
            a = 12'h815 + 12'(8 * (i % 5) + 64 * (i / 5));
            v = 8'(i * 29 + 71);
            rd(a, 8'h00, "window reset");
            wr(a, v);
            rd(a, v, "window readback");
            chk(offset_upper_bits[i*6 +: 6], v[5:0], "offset");
            chk(window_write_protect[i], v[7], "protect");
            chk(window_attribute_select[i], v[6], "space");
        end
    endtask : t_windows
    task automatic t_detect;
        vs1 = 2'h1;
        wr(12'h816, 8'hCF);
        rd(12'h816, 8'h42, "detect read");
        vs1 = 2'h0;
        vs2 = 2'h1;
        wr(12'h816, 8'h30);
        rd(12'h816, 8'h90, "sense read");
        rd(12'h800, 8'h00, "unmapped");
    endtask : t_detect
    task automatic t_trigger;
        detect_enable = 2'h3;
        wr(12'h816, 8'h20);
        chk(soft_detect_trigger, 2'h1, "trigger");
        @(negedge mclk);
        chk(soft_detect_trigger, 2'h0, "trigger clear");
        wr(12'h856, 8'h20);
        chk(soft_detect_trigger, 2'h2, "trigger socket 1");
        detect_enable = 2'h0;
        wr(12'h816, 8'h20);
        chk(soft_detect_trigger, 2'h0, "trigger off");
    endtask : t_trigger
    task automatic t_ring;
        wr(12'h816, 8'h10);
        present = 2'h2;
        repeat (5) @(negedge mclk);
        chk(ring_indicate_output_n, 2'h2, "ring");
        present = 2'h3;
        repeat (5) @(negedge mclk);
        chk(ring_indicate_output_n, 2'h2, "ring hold");
        status_change_clear = 2'h1;
        @(negedge mclk);
        status_change_clear = 2'h0;
        @(negedge mclk);
        chk(ring_indicate_output_n, 2'h3, "ring release");
        wr(12'h816, 8'h00);
        present = 2'h2;
        repeat (5) @(negedge mclk);
        chk(ring_indicate_output_n, 2'h3, "wake off");
        present = 2'h3;
        repeat (5) @(negedge mclk);
    endtask : t_ring
    task automatic t_removal;
        for (int c = 1; c >= 0; c--) begin
            wr(12'h815, 8'h3F);
            wr(12'h816, 8'(2 * c));
            present = 2'h2;
            repeat (5) @(negedge mclk);
            chk(offset_upper_bits[5:0], c ? 6'h00 : 6'h3F, "removal");
            present = 2'h3;
            repeat (5) @(negedge mclk);
        end
    endtask : t_removal
    task automatic t_platform;
        wr(12'h81E, 8'hFF);
        rd(12'h81E, 8'h04, "global");
        for (int p = 1; p >= 0; p--) begin
            wr(12'h815, 8'h15);
            wr(12'h816, 8'h12);
            pme_enable = p[0];
            platform_reset = 1;
            @(negedge mclk);
            platform_reset = 0;
            chk(offset_upper_bits[5:0], 6'h00, "platform window");
            rd(12'h816, p ? 8'h92 : 8'h80, "platform detect");
        end
        chk(flag_clear_select, 1'b1, "flag mode kept");
        detect_flag_write1 = 2'h1;
        @(negedge mclk);
        detect_flag_write1 = 2'h0;
        chk(soft_detect_trigger, 2'h0, "flag writeback");
    endtask : t_platform
    task automatic complete_run;
        $display("errors=%0d compares=%0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : complete_run
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            complete_run();
        end
    end
    initial begin
        repeat (4) @(negedge mclk);
        srst = 0;
        t_windows();
        t_detect();
        t_trigger();
        t_ring();
        t_removal();
        t_platform();
        complete_run();
    end
endmodule : csw_socket_regs_tb
`default_nettype wire
